//--- core/i2c_byte_engine.sv
// Bit-level I2C master engine: start, stop, byte write and byte read
`timescale 1ns/10ps
module i2c_byte_engine
    import boot_loader_pkg::*;
(
    // Clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst,
    // Sequencer link
    i2c_engine_if.engine eng,
    // Synchronised line levels and drive enables
    input  wire logic   sda_in,
    output logic        scl_oe,
    output logic        sda_oe
);
    eng_state_t  state, next_state;
    logic [7:0]  pre_cnt, next_pre_cnt;
    logic [15:0] per_cnt, next_per_cnt;
    logic [8:0]  shifter, next_shifter;
    logic [8:0]  rx, next_rx;
    logic [3:0]  bit_cnt, next_bit_cnt;
    logic        next_scl_oe, next_sda_oe, done, next_done, nack, next_nack;
    logic [7:0]  rd_byte, next_rd_byte;
    logic        tick, phase_end, high_phase;
    logic [15:0] limit;

    assign eng.done    = done;
    assign eng.rd_byte = rd_byte;
    assign eng.nack    = nack;

    // Module clock tick from the prescaler; a zero period count is treated as one
    assign tick       = (pre_cnt == eng.psc);
    assign high_phase = (state == E_START_B) || (state == E_START_C) || (state == E_BIT_HI)
                        || (state == E_STOP_B) || (state == E_STOP_C);
    assign limit      = high_phase ? eng.clk_high : eng.clk_low;
    assign phase_end  = tick && ({1'b0, per_cnt} + 17'h00001 >= {1'b0, limit});

    // ****************************************
    // Bit sequencing
    // ****************************************
    // Line levels are never compared with what is driven: lost arbitration,
    // a busy bus and being addressed as a slave all go unnoticed.  RULE8
    always_comb begin
        next_state   = state;
        next_shifter = shifter;
        next_rx      = rx;
        next_bit_cnt = bit_cnt;
        next_scl_oe  = scl_oe;
        next_sda_oe  = sda_oe;
        next_rd_byte = rd_byte;
        next_nack    = nack;
        next_done    = 1'b0;
        next_pre_cnt = (state == E_IDLE || tick) ? 8'h00 : pre_cnt + 8'h01;
        next_per_cnt = (state == E_IDLE || phase_end) ? 16'h0000 :
                       (tick ? per_cnt + 16'h0001 : per_cnt);
        case (state)
            E_IDLE: begin
                if (eng.cmd_valid) begin
                    next_bit_cnt = 4'h0;
                    case (eng.cmd)
                        CMD_START: next_state = E_START_A;
                        CMD_WRITE: begin
                            next_shifter = {eng.wr_byte, 1'b1};
                            next_state   = E_BIT_LO;
                        end
                        CMD_READ: begin
                            next_shifter = {8'hff, eng.master_nack};
                            next_state   = E_BIT_LO;
                        end
                        default: next_state = E_STOP_A;
                    endcase
                end
            end
            // Release SDA while SCL keeps its level, so a repeated start is clean
            E_START_A: begin
                next_sda_oe = 1'b0;
                if (phase_end) next_state = E_START_B;
            end
            E_START_B: begin
                next_scl_oe = 1'b0;
                if (phase_end) next_state = E_START_C;
            end
            E_START_C: begin
                next_sda_oe = 1'b1;
                if (phase_end) begin
                    next_state = E_IDLE;
                    next_done  = 1'b1;
                end
            end
            E_BIT_LO: begin
                next_scl_oe = 1'b1;
                next_sda_oe = ~shifter[8];
                if (phase_end) next_state = E_BIT_HI;
            end
            E_BIT_HI: begin
                next_scl_oe = 1'b0;
                if (phase_end) begin
                    next_rx      = {rx[7:0], sda_in};
                    next_shifter = {shifter[7:0], 1'b1};
                    next_bit_cnt = bit_cnt + 4'h1;
                    next_state   = E_BIT_LO;
                    if (bit_cnt == 4'h8) begin
                        // Hold SCL low between bytes
                        next_scl_oe  = 1'b1;
                        next_rd_byte = rx[7:0];
                        next_nack    = sda_in;
                        next_done    = 1'b1;
                        next_state   = E_IDLE;
                    end
                end
            end
            E_STOP_A: begin
                next_scl_oe = 1'b1;
                next_sda_oe = 1'b1;
                if (phase_end) next_state = E_STOP_B;
            end
            E_STOP_B: begin
                next_scl_oe = 1'b0;
                if (phase_end) next_state = E_STOP_C;
            end
            E_STOP_C: begin
                next_sda_oe = 1'b0;
                if (phase_end) begin
                    next_state = E_IDLE;
                    next_done  = 1'b1;
                end
            end
            default: next_state = E_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state   <= E_IDLE;
            pre_cnt <= 8'h00;
            per_cnt <= 16'h0000;
            shifter <= 9'h1ff;
            rx      <= 9'h000;
            bit_cnt <= 4'h0;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            rd_byte <= 8'h00;
            nack    <= 1'b0;
            done    <= 1'b0;
        end else begin
            state   <= next_state;
            pre_cnt <= next_pre_cnt;
            per_cnt <= next_per_cnt;
            shifter <= next_shifter;
            rx      <= next_rx;
            bit_cnt <= next_bit_cnt;
            scl_oe  <= next_scl_oe;
            sda_oe  <= next_sda_oe;
            rd_byte <= next_rd_byte;
            nack    <= next_nack;
            done    <= next_done;
        end
    end
endmodule

//--- core/i2c_eeprom_boot_loader.sv
// Boot loader that copies an image from a serial EEPROM into internal memory
// How it works
// RULE1: Boot source is addressed as slave 0x50.
// RULE2: EEPROM reads bytes, takes 16-bit pointer.
// RULE3: Other sources must mimic EEPROM as slave.
// RULE4: Option one: prescaler set to 1.
// RULE5: Option two: prescaler set to 0.
// RULE6: Start at 100 kHz, 50 percent duty.
// RULE7: Stream timing words apply to later reads.
// RULE8: No arbitration, busy or slave checks.
// RULE9: Other masters wait until boot finishes.
// RULE10: Acknowledge checked only in pointer write.
// RULE11: Missing EEPROM: watchdog on, force reset.
// RULE12: Later read address phases ignore acknowledge.
// RULE13: Words low byte first; key 0x08AA.
// RULE14: Byte 3 prescaler, then high, low periods.
// RULE15: Skip reserved; entry upper half first.
// RULE16: Copy blocks until zero block size.
// RULE17: First message: pointer 0x0000, read key.
// RULE18: Every later read fetches two bytes.
// RULE19: Wrong key takes the reset path.
// RULE20: Block words go to consecutive addresses.
`timescale 1ns/10ps
`include "boot_loader_defines.svh"
module i2c_eeprom_boot_loader
    import boot_loader_pkg::*;
(
    // Clock and reset
    input  wire logic   ref_clk,
    input  wire logic   rst,
    // Control
    input  wire logic   boot_start,
    input  wire logic   timing_option_one,
    // I2C pins
    input  wire logic   scl_in,
    output logic        scl_out,
    output logic        scl_oe,
    input  wire logic   sda_in,
    output logic        sda_out,
    output logic        sda_oe,
    // Memory write port
    output logic        mem_wr_en,
    output logic [31:0] mem_addr,
    output logic [15:0] mem_wr_data,
    // Status
    output logic        busy,
    output logic        boot_done,
    output logic [31:0] entry_point,
    output logic        watchdog_enable,
    output logic        reset_request
);
    i2c_engine_if eng ();

    load_state_t  state, next_state;
    blk_phase_t   blk_phase, next_blk_phase;
    logic         issued, next_issued, in_blocks, next_in_blocks;
    logic [7:0]   word_lo, next_word_lo;
    logic [15:0]  word, next_word, blk_count, next_blk_count;
    logic [3:0]   word_idx, next_word_idx;
    logic [7:0]   psc, next_psc, psc_new, next_psc_new;
    logic [15:0]  clk_high, next_clk_high, clk_low, next_clk_low;
    logic [15:0]  clkh_new, next_clkh_new;
    logic [31:0]  dest_addr, next_dest_addr, next_mem_addr, next_entry_point;
    logic [15:0]  next_mem_wr_data;
    logic         next_mem_wr_en, next_busy, next_boot_done, next_fail;
    logic         scl_meta, scl_sync, sda_meta, sda_sync;
    logic         op_done, eng_scl_oe, eng_sda_oe;

    // Which states hand a command to the engine
    function automatic logic is_op(input load_state_t s);
        is_op = (s != L_IDLE) && (s != L_USE) && (s != L_DONE) && (s != L_FAIL);
    endfunction

    // ****************************************
    // Engine command decode
    // ****************************************
    assign eng.cmd_valid   = is_op(state) && !issued;
    assign eng.master_nack = (state == L_W_RDHI);
    assign eng.psc         = psc;
    assign eng.clk_high    = clk_high;
    assign eng.clk_low     = clk_low;
    assign op_done         = issued && eng.done;

    always_comb begin
        eng.cmd     = CMD_WRITE;
        eng.wr_byte = 8'h00;
        case (state)
            L_P_START, L_W_START: eng.cmd = CMD_START;
            L_P_DEVW: eng.wr_byte = {`SLAVE_ADDR, 1'b0};                   // RULE1
            L_P_PTRH: eng.wr_byte = 8'(`PTR_INIT >> 8);                    // RULE17
            L_P_PTRL: eng.wr_byte = 8'(`PTR_INIT & 16'h00ff);              // RULE2
            L_W_DEVR: eng.wr_byte = {`SLAVE_ADDR, 1'b1};                   // RULE1
            L_W_RDLO, L_W_RDHI: eng.cmd = CMD_READ;                        // RULE18
            L_W_STOP: eng.cmd = CMD_STOP;
            default: eng.cmd = CMD_WRITE;
        endcase
    end

    i2c_byte_engine u_engine (
        .ref_clk (ref_clk),
        .rst     (rst),
        .eng     (eng.engine),
        .sda_in  (sda_sync),
        .scl_oe  (eng_scl_oe),
        .sda_oe  (eng_sda_oe)
    );

    // ****************************************
    // Load sequencer
    // ****************************************
    always_comb begin
        next_state       = state;
        next_blk_phase   = blk_phase;
        next_issued      = is_op(state) && !op_done;
        next_in_blocks   = in_blocks;
        next_word_lo     = word_lo;
        next_word        = word;
        next_blk_count   = blk_count;
        next_word_idx    = word_idx;
        next_psc         = psc;
        next_psc_new     = psc_new;
        next_clk_high    = clk_high;
        next_clk_low     = clk_low;
        next_clkh_new    = clkh_new;
        next_dest_addr   = dest_addr;
        next_mem_addr    = mem_addr;
        next_entry_point = entry_point;
        next_mem_wr_data = mem_wr_data;
        next_mem_wr_en   = 1'b0;
        case (state)
            L_IDLE: begin
                if (boot_start) begin
                    next_psc       = timing_option_one ? `PSC_OPT_ONE : `PSC_OPT_TWO; // RULE4 RULE5
                    next_clk_high  = 16'(`CLK_HALF_INIT);                          // RULE6
                    next_clk_low   = 16'(`CLK_HALF_INIT);                          // RULE6
                    next_word_idx  = `WORD_KEY;
                    next_in_blocks = 1'b0;
                    next_state     = L_P_START;
                end
            end
            L_P_START: if (op_done) next_state = L_P_DEVW;
            // A missing acknowledge here means no EEPROM answers
            L_P_DEVW: if (op_done) next_state = eng.nack ? L_FAIL : L_P_PTRH; // RULE10 RULE11
            L_P_PTRH: if (op_done) next_state = eng.nack ? L_FAIL : L_P_PTRL; // RULE10
            L_P_PTRL: if (op_done) next_state = eng.nack ? L_FAIL : L_W_START; // RULE10
            L_W_START: if (op_done) next_state = L_W_DEVR;
            // No acknowledge check: a silent slave lets the load go on, reading all-ones bytes
            L_W_DEVR: if (op_done) next_state = L_W_RDLO;                 // RULE12
            L_W_RDLO: begin
                if (op_done) begin
                    next_word_lo = eng.rd_byte;
                    next_state   = L_W_RDHI;
                end
            end
            L_W_RDHI: begin
                if (op_done) begin
                    next_word  = {eng.rd_byte, word_lo};                  // RULE13
                    next_state = L_W_STOP;
                end
            end
            L_W_STOP: if (op_done) next_state = L_USE;
            L_USE: begin
                next_state = L_W_START;
                if (!in_blocks) begin
                    next_word_idx = word_idx + 4'h1;
                    case (word_idx)
                        `WORD_KEY: if (word != `KEY_WORD) next_state = L_FAIL; // RULE13 RULE19
                        `WORD_PSC: next_psc_new = word[7:0];              // RULE14
                        `WORD_CLKH: next_clkh_new = word;                 // RULE14
                        `WORD_CLKL: begin
                            // New timing takes effect from the next message on
                            next_psc      = psc_new;                      // RULE7
                            next_clk_high = clkh_new;                     // RULE7
                            next_clk_low  = word;                         // RULE14
                        end
                        `WORD_ENTRY_HI: next_entry_point[31:16] = {8'h00, word[7:0]}; // RULE15
                        `WORD_ENTRY_LO: begin
                            next_entry_point[15:0] = word;                // RULE15
                            next_in_blocks         = 1'b1;
                            next_blk_phase         = B_SIZE;
                        end
                        default: next_word_idx = word_idx + 4'h1;         // RULE15
                    endcase
                end else begin
                    case (blk_phase)
                        B_SIZE: begin
                            if (word == 16'h0000) begin
                                next_state = L_DONE;                      // RULE16
                            end else begin
                                next_blk_count = word;
                                next_blk_phase = B_ADDR_HI;
                            end
                        end
                        B_ADDR_HI: begin
                            next_dest_addr[31:16] = word;
                            next_blk_phase        = B_ADDR_LO;
                        end
                        B_ADDR_LO: begin
                            next_dest_addr[15:0] = word;
                            next_blk_phase       = B_DATA;
                        end
                        default: begin
                            next_mem_wr_en   = 1'b1;                      // RULE20
                            next_mem_addr    = dest_addr;
                            next_mem_wr_data = word;
                            next_dest_addr   = dest_addr + 32'h00000001;  // RULE20
                            next_blk_count   = blk_count - 16'h0001;
                            if (blk_count == 16'h0001) next_blk_phase = B_SIZE; // RULE16
                        end
                    endcase
                end
            end
            L_DONE, L_FAIL: next_state = state;
            default: next_state = L_IDLE;
        endcase
        // Outcome flags rise with the state change, so busy never drops ahead of them
        next_boot_done = boot_done || (next_state == L_DONE);             // RULE16
        next_fail      = watchdog_enable || (next_state == L_FAIL);       // RULE11 RULE19
        next_busy = (next_state != L_IDLE) && (next_state != L_DONE) && (next_state != L_FAIL);
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state           <= L_IDLE;
            blk_phase       <= B_SIZE;
            issued          <= 1'b0;
            in_blocks       <= 1'b0;
            word_lo         <= 8'h00;
            word            <= 16'h0000;
            blk_count       <= 16'h0000;
            word_idx        <= 4'h0;
            psc             <= `PSC_OPT_TWO;
            psc_new         <= 8'h00;
            clk_high        <= 16'(`CLK_HALF_INIT);
            clk_low         <= 16'(`CLK_HALF_INIT);
            clkh_new        <= 16'h0000;
            dest_addr       <= 32'h00000000;
            mem_addr        <= 32'h00000000;
            entry_point     <= 32'h00000000;
            mem_wr_data     <= 16'h0000;
            mem_wr_en       <= 1'b0;
            busy            <= 1'b0;
            boot_done       <= 1'b0;
            watchdog_enable <= 1'b0;
            reset_request   <= 1'b0;
        end else begin
            state           <= next_state;
            blk_phase       <= next_blk_phase;
            issued          <= next_issued;
            in_blocks       <= next_in_blocks;
            word_lo         <= next_word_lo;
            word            <= next_word;
            blk_count       <= next_blk_count;
            word_idx        <= next_word_idx;
            psc             <= next_psc;
            psc_new         <= next_psc_new;
            clk_high        <= next_clk_high;
            clk_low         <= next_clk_low;
            clkh_new        <= next_clkh_new;
            dest_addr       <= next_dest_addr;
            mem_addr        <= next_mem_addr;
            entry_point     <= next_entry_point;
            mem_wr_data     <= next_mem_wr_data;
            mem_wr_en       <= next_mem_wr_en;
            busy            <= next_busy;
            boot_done       <= next_boot_done;
            watchdog_enable <= next_fail;
            reset_request   <= next_fail;
        end
    end

    // ****************************************
    // Pin synchronisers and drivers
    // ****************************************
    // Open-drain: the data level driven is always low, only the enables move
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            scl_meta <= 1'b1;
            scl_sync <= 1'b1;
            sda_meta <= 1'b1;
            sda_sync <= 1'b1;
            scl_out  <= 1'b0;
            sda_out  <= 1'b0;
        end else begin
            scl_meta <= scl_in;
            scl_sync <= scl_meta;
            sda_meta <= sda_in;
            sda_sync <= sda_meta;
            scl_out  <= 1'b0;
            sda_out  <= 1'b0;
        end
    end

    assign scl_oe = eng_scl_oe;
    assign sda_oe = eng_sda_oe;
endmodule

//--- pkg/boot_loader_defines.svh
// Constants of the serial EEPROM boot loader
`ifndef BOOT_LOADER_DEFINES_SVH
`define BOOT_LOADER_DEFINES_SVH

// ****************************************
// Bus addressing
// ****************************************
`define SLAVE_ADDR      7'h50
`define PTR_INIT        16'h0000
`define KEY_WORD        16'h08aa

// ****************************************
// Timing
// ****************************************
`define PSC_OPT_ONE     8'h01
`define PSC_OPT_TWO     8'h00
`define MOD_CLK_HZ      12000000
`define STD_BIT_HZ      100000
`define CLK_HALF_INIT   (`MOD_CLK_HZ / `STD_BIT_HZ / 2)

// ****************************************
// Stream word positions
// ****************************************
`define WORD_KEY        4'h0
`define WORD_PSC        4'h1
`define WORD_CLKH       4'h2
`define WORD_CLKL       4'h3
`define WORD_ENTRY_HI   4'h9
`define WORD_ENTRY_LO   4'ha

`endif

//--- pkg/boot_loader_pkg.sv
// Types shared by the boot loader modules
package boot_loader_pkg;

    typedef enum logic [1:0] {
        CMD_START = 2'b00,
        CMD_WRITE = 2'b01,
        CMD_READ  = 2'b10,
        CMD_STOP  = 2'b11
    } i2c_cmd_t;

    typedef enum logic [3:0] {
        E_IDLE    = 4'b0000,
        E_START_A = 4'b0001,
        E_START_B = 4'b0010,
        E_START_C = 4'b0011,
        E_BIT_LO  = 4'b0100,
        E_BIT_HI  = 4'b0101,
        E_STOP_A  = 4'b0110,
        E_STOP_B  = 4'b0111,
        E_STOP_C  = 4'b1000
    } eng_state_t;

    typedef enum logic [3:0] {
        L_IDLE    = 4'b0000,
        L_P_START = 4'b0001,
        L_P_DEVW  = 4'b0010,
        L_P_PTRH  = 4'b0011,
        L_P_PTRL  = 4'b0100,
        L_W_START = 4'b0101,
        L_W_DEVR  = 4'b0110,
        L_W_RDLO  = 4'b0111,
        L_W_RDHI  = 4'b1000,
        L_W_STOP  = 4'b1001,
        L_USE     = 4'b1010,
        L_DONE    = 4'b1011,
        L_FAIL    = 4'b1100
    } load_state_t;

    typedef enum logic [1:0] {
        B_SIZE    = 2'b00,
        B_ADDR_HI = 2'b01,
        B_ADDR_LO = 2'b10,
        B_DATA    = 2'b11
    } blk_phase_t;

endpackage

//--- pkg/i2c_engine_if.sv
// Command and timing link between the loader sequencer and the byte engine
`timescale 1ns/10ps
interface i2c_engine_if;
    import boot_loader_pkg::*;
    logic           cmd_valid;
    i2c_cmd_t       cmd;
    logic [7:0]     wr_byte;
    logic           master_nack;
    logic [7:0]     psc;
    logic [15:0]    clk_high;
    logic [15:0]    clk_low;
    logic           done;
    logic [7:0]     rd_byte;
    logic           nack;

    modport loader (output cmd_valid, cmd, wr_byte, master_nack, psc, clk_high, clk_low,
                    input  done, rd_byte, nack);
    modport engine (input  cmd_valid, cmd, wr_byte, master_nack, psc, clk_high, clk_low,
                    output done, rd_byte, nack);
endinterface

//--- tb/boot_loader_checker.sv
// Port checker of the serial EEPROM boot loader
`timescale 1ns/10ps
module boot_loader_checker (
    input wire logic        ref_clk, rst, boot_start, scl_oe, sda_oe, mem_wr_en,
    input wire logic        busy, boot_done, watchdog_enable, reset_request,
    input wire logic [31:0] entry_point
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_release:
        assert property (disable iff (1'b0) rst |=> !busy && !scl_oe && !sda_oe)
        else $error("reset left outputs active");
    a_start_cause:
        assert property ($rose(busy) |-> $past(boot_start) || $past(boot_start, 2))
        else $error("load began without start");
    a_fail_pair: assert property (watchdog_enable == reset_request)
        else $error("watchdog and reset request differ");
    a_fail_sticky: assert property (watchdog_enable |=> watchdog_enable)
        else $error("failure flag dropped");
    a_done_sticky: assert property (boot_done |=> boot_done)
        else $error("done flag dropped");
    a_busy_ends: assert property ($fell(busy) |-> boot_done || watchdog_enable)
        else $error("load ended without outcome");
    a_wr_pulse: assert property (mem_wr_en |=> !mem_wr_en)
        else $error("write pulse too long");
    a_entry_top: assert property (entry_point[31:24] == 8'h00)
        else $error("entry top byte not zero");
    a_idle_bus:
        assert property (!busy && !watchdog_enable |-> !scl_oe && !sda_oe)
        else $error("bus driven while idle");
endmodule
bind i2c_eeprom_boot_loader boot_loader_checker u_boot_loader_checker (.*);

//--- tb/eeprom_model.sv
// Behavioural serial EEPROM answering on the boot bus
`timescale 1ns/10ps
module eeprom_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic present,
    output logic     sda_oe
);
    logic [7:0]  mem [0:63];
    logic [7:0]  sh;
    logic [15:0] ptr;
    logic        act = 0, rd, sel, ld;
    int          bitn, byten;
    initial sda_oe = 0;
    // Only reacts to frames; never begins a transfer of its own
    always @(negedge sda) if (scl) begin act = 1; bitn = 0; byten = 0; end
    always @(posedge sda) if (scl) act = 0;
    always @(posedge scl) if (act) begin sh = {sh[6:0], sda}; bitn++; end
    always @(negedge scl) if (act) begin
        if (bitn == 8) begin
            if (byten == 0) begin rd = sh[0]; sel = present && sh[7:1] == 7'h50; end
            else if (!rd) ptr = byten == 1 ? {sh, ptr[7:0]} : {ptr[15:8], sh};
            sda_oe = sel && (byten == 0 || !rd);
        end else if (bitn == 9) begin
            // A master nack ends the read, so the line is released for the stop
            ld = sel && rd && (byten == 0 || !sh[0]);
            byten++;
            bitn = 0;
            if (ld) begin sh = mem[ptr[5:0]]; ptr++; end
            sda_oe = ld && !sh[7];
        end else sda_oe = sel && rd && byten > 0 && !sh[7];
    end
endmodule

//--- tb/test_i2c_eeprom_boot_loader.sv
// Self-checking bench of the serial EEPROM boot loader
`timescale 1ns/10ps
module test_i2c_eeprom_boot_loader;
    logic         ref_clk = 0, rst = 1, boot_start = 0, timing_option_one = 0, present = 1;
    logic         scl_out, scl_oe, sda_out, sda_oe, mem_wr_en, busy, boot_done, ee_oe;
    logic         watchdog_enable, reset_request;
    logic [31:0]  mem_addr, entry_point;
    logic [15:0]  mem_wr_data;
    logic [47:0]  wr_q [$];
    wire          scl_in, sda_in;
    int           fail_count = 0, compares = 0, cycles = 0, t0;
    // Key, prescaler, ignored byte, periods 4/4, reserved, entry, one block, end
    logic [271:0] img =
        272'haa08005a04000400_00000000000000000000_12007856_020000000001_3412cdab_0000;
    assign scl_in = scl_oe !== 1'b1;
    // Delay keeps data edges behind the clock edge launched with them
    assign #1 sda_in = !(sda_oe === 1'b1 || ee_oe === 1'b1);
    i2c_eeprom_boot_loader u_i2c_eeprom_boot_loader (.*);
    eeprom_model u_eeprom_model (.scl(scl_in), .sda(sda_in), .present(present), .sda_oe(ee_oe));
    always #20 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (mem_wr_en === 1'b1) wr_q.push_back({mem_addr, mem_wr_data});
        if (cycles == 90000) begin
            fail_count++;
            conclude();
        end
    end
    task check(string what, logic [47:0] exp, logic [47:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask
    task boot(logic opt, logic [7:0] key);
        int n;
        rst <= 1;
        repeat (16) @(posedge ref_clk);
        rst <= 0;
        for (int i = 0; i < 34; i++) u_eeprom_model.mem[i] = img[271 - 8 * i -: 8];
        u_eeprom_model.mem[0] = key;
        wr_q = {};
        t0 = cycles;
        @(posedge ref_clk);
        timing_option_one <= opt;
        boot_start <= 1;
        @(posedge ref_clk);
        boot_start <= 0;
        repeat (2) @(posedge scl_oe);
        wait (scl_oe === 1'b0);
        n = 0;
        while (scl_oe === 1'b0) begin @(posedge ref_clk); n++; end
        n = n - 60 * (opt + 1);
        check("high phase", 1, n > -3 && n < 3);
        while (boot_done !== 1'b1 && watchdog_enable !== 1'b1) @(posedge ref_clk);
    endtask
    task test_full_load;
        boot(1, 8'haa);
        check("done", 1, boot_done);
        check("fast", 1, cycles - t0 < 60000);
        check("entry", 32'h0012_5678, entry_point);
        check("count", 2, wr_q.size());
        check("w0", {32'h100, 16'h1234}, wr_q[0]);
        check("w1", {32'h101, 16'habcd}, wr_q[1]);
        check("wd", 0, watchdog_enable);
        check("idle pins", 0, {busy, scl_out, sda_out});
    endtask
    task test_bad_key;
        boot(0, 8'hab);
        check("wd", 1, watchdog_enable);
        check("rr", 1, reset_request);
        check("done", 0, boot_done);
    endtask
    task test_no_slave;
        present = 0;
        boot(0, 8'haa);
        check("wd", 1, watchdog_enable);
        check("count", 0, wr_q.size());
        present = 1;
    endtask
    task conclude;
        $display("Comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        test_full_load();
        test_bad_key();
        test_no_slave();
        conclude();
    end
endmodule
